// [logic/ism_source_map.sv]
// Interrupt source map for three aggregator groups with direct vectors
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
module ism_source_map (
    input  wire logic                            ref_clk,
    input  wire logic                            resetn,
    input  wire logic                            wb_cyc_i,
    input  wire logic                            wb_stb_i,
    input  wire logic                            wb_we_i,
    input  wire logic [ism_pkg::ADR_W-1:0]       wb_adr_i,
    input  wire logic [3:0]                      wb_sel_i,
    input  wire logic [31:0]                     wb_dat_i,
    output logic      [31:0]                     wb_dat_o,
    output logic                                 wb_ack_o,
    input  wire logic [ism_pkg::DMA_CHANNELS-1:0] dma_channel_event,
    input  wire logic [1:0]                      fan_speed_meter_event,
    input  wire logic                            conv_single_event,
    input  wire logic                            conv_repeat_event,
    input  wire logic [1:0]                      led_blinker_watchdog_event,
    input  wire logic                            system_watchdog_event,
    input  wire logic                            one_second_event,
    input  wire logic                            sub_second_event,
    input  wire logic                            system_power_present_event,
    input  wire logic                            calendar_periodic_event,
    input  wire logic                            calendar_alarm_event,
    input  wire logic                            battery_domain_input_zero_n,
    output logic      [ism_pkg::NVEC-1:0]        direct_vector,
    output logic      [ism_pkg::GROUPS-1:0]      agg_request,
    output logic                                 wake_request,
    output logic                                 irq
);
    import ism_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic            bat_meta;
    logic            bat_sync;
    logic [31:0]     src      [0:GROUPS-1];
    logic [31:0]     src_q    [0:GROUPS-1];
    logic [31:0]     rise     [0:GROUPS-1];
    logic [31:0]     sts      [0:GROUPS-1];
    logic [31:0]     msk      [0:GROUPS-1];
    logic [NVEC-1:0] next_direct;
    logic [31:0]     next_rdata;
    logic            wb_req;
    logic            wb_rd;
    logic            wb_wr;

    // Address match, used by decode and read mux
    function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        merge = res;
    endfunction

    // ----------------------------------------
    // Battery-domain pin synchroniser
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bat_meta <= 1'b1;
            bat_sync <= 1'b1;
        end else begin
            bat_meta <= battery_domain_input_zero_n;
            bat_sync <= bat_meta;
        end
    end

    // ----------------------------------------
    // Source routing into group bits
    // ----------------------------------------
    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            src[g] = 32'h0000_0000;
        end
        for (int k = 0; k < DMA_CHANNELS; k++) begin
            src[G14][BIT_DMA_FIRST + k] = dma_channel_event[k];
        end
        src[G17][BIT_FAN0]         = fan_speed_meter_event[0];
        src[G17][BIT_FAN1]         = fan_speed_meter_event[1];
        src[G17][BIT_CONV_SINGLE]  = conv_single_event;
        src[G17][BIT_CONV_REPEAT]  = conv_repeat_event;
        src[G17][BIT_LED0]         = led_blinker_watchdog_event[0];
        src[G17][BIT_LED1]         = led_blinker_watchdog_event[1];
        src[G21][BIT_SYS_WDT]      = system_watchdog_event;
        src[G21][BIT_ONE_SEC]      = one_second_event;
        src[G21][BIT_SUB_SEC]      = sub_second_event;
        src[G21][BIT_PWR_PRES]     = system_power_present_event;
        src[G21][BIT_CAL_PERIODIC] = calendar_periodic_event;
        src[G21][BIT_CAL_ALARM]    = calendar_alarm_event;
        src[G21][BIT_BAT_IN0]      = ~bat_sync;
    end

    // ----------------------------------------
    // Direct vector drive
    // ----------------------------------------
    always_comb begin
        next_direct = '0;
        for (int k = 0; k < DMA_CHANNELS; k++) begin
            next_direct[VEC_DMA_FIRST + k] = src[G14][BIT_DMA_FIRST + k];
        end
        next_direct[VEC_FAN0]         = src[G17][BIT_FAN0];
        next_direct[VEC_FAN1]         = src[G17][BIT_FAN1];
        next_direct[VEC_CONV_SINGLE]  = src[G17][BIT_CONV_SINGLE];
        next_direct[VEC_CONV_REPEAT]  = src[G17][BIT_CONV_REPEAT];
        next_direct[VEC_LED0]         = src[G17][BIT_LED0];
        next_direct[VEC_LED1]         = src[G17][BIT_LED1];
        next_direct[VEC_SYS_WDT]      = src[G21][BIT_SYS_WDT];
        next_direct[VEC_ONE_SEC]      = src[G21][BIT_ONE_SEC];
        next_direct[VEC_SUB_SEC]      = src[G21][BIT_SUB_SEC];
        next_direct[VEC_PWR_PRES]     = src[G21][BIT_PWR_PRES];
        next_direct[VEC_CAL_PERIODIC] = src[G21][BIT_CAL_PERIODIC];
        next_direct[VEC_CAL_ALARM]    = src[G21][BIT_CAL_ALARM];
        next_direct[VEC_BAT_IN0]      = src[G21][BIT_BAT_IN0];
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            direct_vector <= '0;
        end else begin
            direct_vector <= next_direct;
        end
    end

    // Wake only from group twenty-one wake-capable sources
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= |(src[G21] & WAKE21);
        end
    end

    // ----------------------------------------
    // Event edge detection
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int g = 0; g < GROUPS; g++) begin
                src_q[g] <= 32'h0000_0000;
            end
        end else begin
            for (int g = 0; g < GROUPS; g++) begin
                src_q[g] <= src[g];
            end
        end
    end

    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            rise[g] = src[g] & ~src_q[g] & USED[g];
        end
    end

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_rd  = wb_req & ~wb_we_i;
    assign wb_wr  = wb_req & wb_we_i;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        for (int g = 0; g < GROUPS; g++) begin
            if (hit(wb_adr_i, STS_OFF[g])) begin
                next_rdata = sts[g];
            end
            if (hit(wb_adr_i, MSK_OFF[g])) begin
                next_rdata = msk[g];
            end
            if (hit(wb_adr_i, SRC_OFF[g])) begin
                next_rdata = src[g] & USED[g];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_rd) begin
            wb_dat_o <= next_rdata;
        end
    end

    // ----------------------------------------
    // Sticky status, read clears, set wins
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int g = 0; g < GROUPS; g++) begin
                sts[g] <= STS_RST;
            end
        end else begin
            for (int g = 0; g < GROUPS; g++) begin
                if (wb_rd && hit(wb_adr_i, STS_OFF[g])) begin
                    sts[g] <= rise[g];
                end else begin
                    sts[g] <= sts[g] | rise[g];
                end
            end
        end
    end

    // Mask registers, reserved bits held at zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int g = 0; g < GROUPS; g++) begin
                msk[g] <= MSK_RST;
            end
        end else begin
            for (int g = 0; g < GROUPS; g++) begin
                if (wb_wr && hit(wb_adr_i, MSK_OFF[g])) begin
                    msk[g] <= merge(msk[g], wb_dat_i, wb_sel_i) & USED[g];
                end
            end
        end
    end

    // ----------------------------------------
    // Aggregated requests and interrupt
    // ----------------------------------------
    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            agg_request[g] = |(sts[g] & msk[g]);
        end
    end

    assign irq = |agg_request;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_DMA_DIRECT:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        1'b1 |=> direct_vector[VEC_DMA_FIRST +: DMA_CHANNELS] == $past(dma_channel_event))
        else $error("DMA direct vectors do not follow channels");

    AST_DMA_STATUS:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(dma_channel_event[DMA_CHANNELS-1]) |=> sts[G14][BIT_DMA_FIRST + DMA_CHANNELS - 1])
        else $error("DMA channel 11 event not latched in bit 11");

    AST_FAN:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(fan_speed_meter_event[1]) && (src[G21] == 32'h0) |=> sts[G17][BIT_FAN1] && direct_vector[VEC_FAN1]
            && !wake_request && (direct_vector[VEC_FAN0] == $past(fan_speed_meter_event[0])))
        else $error("Fan meter event misrouted");

    AST_CONV_SINGLE:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(conv_single_event) |=> sts[G17][BIT_CONV_SINGLE] && direct_vector[VEC_CONV_SINGLE])
        else $error("Single conversion event misrouted");

    AST_CONV_REPEAT:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(conv_repeat_event) |=> sts[G17][BIT_CONV_REPEAT] && direct_vector[VEC_CONV_REPEAT])
        else $error("Repeat conversion event misrouted");

    AST_LED_WDT:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(led_blinker_watchdog_event[1]) |=> sts[G17][BIT_LED1] && direct_vector[VEC_LED1])
        else $error("LED blinker watchdog event misrouted");

    AST_SYS_WDT:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(system_watchdog_event) |=> sts[G21][BIT_SYS_WDT] && direct_vector[VEC_SYS_WDT] && wake_request)
        else $error("System watchdog event misrouted or not waking");

    AST_ONE_SEC:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(one_second_event) |=> sts[G21][BIT_ONE_SEC] && direct_vector[VEC_ONE_SEC] && wake_request)
        else $error("One-second event misrouted");

    AST_SUB_SEC:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(sub_second_event) |=> sts[G21][BIT_SUB_SEC] && direct_vector[VEC_SUB_SEC] && wake_request)
        else $error("Sub-second event misrouted");

    AST_PWR_PRES:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(system_power_present_event) |=> sts[G21][BIT_PWR_PRES] && direct_vector[VEC_PWR_PRES])
        else $error("Power present event misrouted");

    AST_CAL_PERIODIC:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(calendar_periodic_event) |=> sts[G21][BIT_CAL_PERIODIC] && direct_vector[VEC_CAL_PERIODIC])
        else $error("Calendar periodic event misrouted");

    AST_CAL_ALARM:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(calendar_alarm_event) |=> sts[G21][BIT_CAL_ALARM] && direct_vector[VEC_CAL_ALARM])
        else $error("Calendar alarm event misrouted");

    AST_BAT_PIN:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        $fell(battery_domain_input_zero_n) ##1 !battery_domain_input_zero_n ##1 !battery_domain_input_zero_n
            |=> sts[G21][BIT_BAT_IN0] && direct_vector[VEC_BAT_IN0] && wake_request)
        else $error("Battery pin low not reported after synchroniser");

    AST_RESERVED:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        ((sts[G14] & ~USED[G14]) == 32'h0) && ((sts[G17] & ~USED[G17]) == 32'h0)
            && ((sts[G21] & ~USED[G21]) == 32'h0) && ((msk[G21] & ~USED[G21]) == 32'h0))
        else $error("Reserved status or mask bit set");

    AST_AGG:
    assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(system_watchdog_event) && msk[G21][BIT_SYS_WDT] && !(wb_wr && hit(wb_adr_i, MSK_OFF[G21]))
            |=> agg_request[G21] && irq)
        else $error("Unmasked group event did not raise aggregated request");

endmodule

// [inc/ism_pkg.sv]
// Constants, offsets and bit maps of the interrupt source map
package ism_pkg;
    // Aggregator groups held in this block
    localparam int GROUPS = 3;
    localparam int G14    = 0;
    localparam int G17    = 1;
    localparam int G21    = 2;

    // Processor vector space
    localparam int NVEC         = 172;
    localparam int AGG_VEC_G14  = 6;
    localparam int AGG_VEC_G21  = 13;
    localparam int DMA_CHANNELS = 11;

    // Bit positions inside the groups
    localparam int BIT_DMA_FIRST    = 1;
    localparam int BIT_FAN0         = 1;
    localparam int BIT_FAN1         = 2;
    localparam int BIT_CONV_SINGLE  = 8;
    localparam int BIT_CONV_REPEAT  = 9;
    localparam int BIT_LED0         = 13;
    localparam int BIT_LED1         = 14;
    localparam int BIT_SYS_WDT      = 2;
    localparam int BIT_ONE_SEC      = 5;
    localparam int BIT_SUB_SEC      = 6;
    localparam int BIT_PWR_PRES     = 7;
    localparam int BIT_CAL_PERIODIC = 8;
    localparam int BIT_CAL_ALARM    = 9;
    localparam int BIT_BAT_IN0      = 11;

    // Direct vector numbers
    localparam int VEC_DMA_FIRST    = 25;
    localparam int VEC_FAN0         = 71;
    localparam int VEC_FAN1         = 72;
    localparam int VEC_CONV_SINGLE  = 78;
    localparam int VEC_CONV_REPEAT  = 79;
    localparam int VEC_LED0         = 83;
    localparam int VEC_LED1         = 84;
    localparam int VEC_SYS_WDT      = 171;
    localparam int VEC_ONE_SEC      = 116;
    localparam int VEC_SUB_SEC      = 117;
    localparam int VEC_PWR_PRES     = 118;
    localparam int VEC_CAL_PERIODIC = 119;
    localparam int VEC_CAL_ALARM    = 120;
    localparam int VEC_BAT_IN0      = 122;

    // Register byte offsets
    localparam int ADR_W = 8;
    localparam logic [7:0] STS_OFF [0:2] = '{8'h00, 8'h08, 8'h10};
    localparam logic [7:0] MSK_OFF [0:2] = '{8'h04, 8'h0c, 8'h14};
    localparam logic [7:0] SRC_OFF [0:2] = '{8'h18, 8'h1c, 8'h20};

    // Implemented bits per group and wake-capable bits
    localparam logic [31:0] USED [0:2] = '{32'h0000_0ffe, 32'h0000_6306, 32'h0000_0be4};
    localparam logic [31:0] WAKE21     = 32'h0000_0be4;

    // Reset values
    localparam logic [31:0] STS_RST = 32'h0000_0000;
    localparam logic [31:0] MSK_RST = 32'h0000_0000;
endpackage

// [bench/ism_nvic_model.sv]
// Behavioural processor vector controller that latches pending vectors
`timescale 1ns/10ps
module ism_nvic_model (
    ref_clk,
    resetn,
    direct_vector,
    irq,
    pend_clear,
    pending,
    irq_seen
);
    import ism_pkg::*;
    input  wire logic            ref_clk;
    input  wire logic            resetn;
    input  wire logic [NVEC-1:0] direct_vector;
    input  wire logic            irq;
    input  wire logic            pend_clear;
    output logic      [NVEC-1:0] pending;
    output logic                 irq_seen;

    logic [NVEC-1:0] last_vec;

    // Rising vector lines become pending until the bench clears them
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            last_vec <= '0;
            pending  <= '0;
            irq_seen <= 1'b0;
        end else begin
            last_vec <= direct_vector;
            if (pend_clear) begin
                pending  <= '0;
                irq_seen <= 1'b0;
            end else begin
                pending  <= pending | (direct_vector & ~last_vec);
                irq_seen <= irq_seen | irq;
            end
        end
    end
endmodule

// [bench/tb.sv]
// Self-checking bench for the interrupt source map
`timescale 1ns/10ps
module tb;
    import ism_pkg::*;
    localparam int TG [0:12] = '{1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2};
    localparam int TB [0:12] = '{1, 2, 8, 9, 13, 14, 2, 5, 6, 7, 8, 9, 11};
    localparam int TV [0:12] = '{71, 72, 78, 79, 83, 84, 171, 116, 117, 118, 119, 120, 122};
    logic            ref_clk    = 1'b0;
    logic            resetn     = 1'b0;
    logic            cyc        = 1'b0;
    logic            stb        = 1'b0;
    logic            we         = 1'b0;
    logic [7:0]      adr        = 8'h00;
    logic [3:0]      sel        = 4'h0;
    logic [31:0]     wdat       = 32'h0;
    logic [23:0]     src        = 24'h0;
    logic            pend_clear = 1'b0;
    logic [31:0]     rdat;
    logic            ack;
    logic [NVEC-1:0] direct_vector;
    logic [NVEC-1:0] pending;
    logic [2:0]      agg_request;
    logic            wake_request;
    logic            irq;
    logic            irq_seen;
    int              failures    = 0;
    int              checks_done = 0;

    always #4 ref_clk = ~ref_clk;

    ism_source_map dut (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .dma_channel_event(src[10:0]), .fan_speed_meter_event(src[12:11]), .conv_single_event(src[13]),
        .conv_repeat_event(src[14]), .led_blinker_watchdog_event(src[16:15]),
        .system_watchdog_event(src[17]), .one_second_event(src[18]), .sub_second_event(src[19]),
        .system_power_present_event(src[20]), .calendar_periodic_event(src[21]),
        .calendar_alarm_event(src[22]), .battery_domain_input_zero_n(~src[23]),
        .direct_vector(direct_vector), .agg_request(agg_request), .wake_request(wake_request), .irq(irq));

    ism_nvic_model nvic (.ref_clk(ref_clk), .resetn(resetn), .direct_vector(direct_vector), .irq(irq),
        .pend_clear(pend_clear), .pending(pending), .irq_seen(irq_seen));

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic chk(input logic [NVEC-1:0] seen, input logic [NVEC-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk32(input logic [31:0] seen, input logic [31:0] exp);
        chk(NVEC'(seen), NVEC'(exp));
    endtask

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int n;
        @(posedge ref_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (ack !== 1'b1) begin
            failures++;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        wb(a, 1'b1, d, s, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(a, 1'b0, 32'h0, 4'hf, q);
    endtask

    function automatic void info(input int i, output int g, output int b, output int v);
        g = (i < 11) ? 0 : TG[i-11];
        b = (i < 11) ? i + 1 : TB[i-11];
        v = (i < 11) ? 25 + i : TV[i-11];
    endfunction

    task automatic drive(input logic [23:0] val);
        @(posedge ref_clk);
        src <= val;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    // One source: direct vector, wake, raw level, sticky status and read clear
    task automatic run_src(input int i);
        int              g;
        int              b;
        int              v;
        logic [31:0]     q;
        logic [NVEC-1:0] e;
        info(i, g, b, v);
        e = '0;
        e[v] = 1'b1;
        @(posedge ref_clk);
        pend_clear <= 1'b1;
        @(posedge ref_clk);
        pend_clear <= 1'b0;
        drive(24'h1 << i);
        chk(direct_vector, e);
        chk(pending, e);
        chk32(32'(wake_request), 32'(g == 2));
        chk32(32'(agg_request), 32'h0);
        rd(8'(8'h18 + 4 * g), q);
        chk32(q, 32'h1 << b);
        drive(24'h0);
        chk(direct_vector, '0);
        chk32(32'(wake_request), 32'h0);
        rd(8'(8 * g), q);
        chk32(q, 32'h1 << b);
        rd(8'(8 * g), q);
        chk32(q, 32'h0);
    endtask

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        int              i;
        int              g;
        int              b;
        int              v;
        logic [31:0]     q;
        logic [31:0]     used [0:2];
        logic [NVEC-1:0] ev;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        for (i = 0; i < 3; i++) begin
            rd(8'(8 * i), q);
            chk32(q, 32'h0);
            rd(8'(8 * i + 4), q);
            chk32(q, 32'h0);
        end
        wr(8'h40, 32'hffff_ffff, 4'hf);
        rd(8'h40, q);
        chk32(q, 32'h0);
        for (i = 0; i < 11; i++) run_src(i);
        for (i = 11; i < 13; i++) run_src(i);
        run_src(13);
        run_src(14);
        for (i = 15; i < 17; i++) run_src(i);
        run_src(17);
        run_src(18);
        run_src(19);
        run_src(20);
        run_src(21);
        run_src(22);
        run_src(23);
        wr(8'h14, 32'hffff_ffff, 4'hf);
        drive(24'h1 << 17);
        drive(24'h0);
        chk32(32'(agg_request), 32'h4);
        chk32(32'(irq), 32'h1);
        chk32(32'(irq_seen), 32'h1);
        wr(8'h14, 32'h0, 4'h0);
        chk32(32'(irq), 32'h1);
        wr(8'h14, 32'h0, 4'h1);
        chk32(32'(irq), 32'h0);
        wr(8'h14, 32'h4, 4'h1);
        chk32(32'(irq), 32'h1);
        rd(8'h10, q);
        chk32(q, 32'h4);
        chk32(32'(irq), 32'h0);
        for (i = 0; i < 3; i++) wr(8'(8 * i + 4), 32'hffff_ffff, 4'hf);
        used = '{32'h0, 32'h0, 32'h0};
        ev = '0;
        for (i = 0; i < 24; i++) begin
            info(i, g, b, v);
            used[g][b] = 1'b1;
            ev[v] = 1'b1;
        end
        drive(24'hff_ffff);
        chk(direct_vector, ev);
        chk32(32'(agg_request), 32'h7);
        chk32(32'(wake_request), 32'h1);
        drive(24'h0);
        for (i = 0; i < 3; i++) begin
            rd(8'(8 * i), q);
            chk32(q, used[i]);
            rd(8'(8 * i + 4), q);
            chk32(q, used[i]);
        end
        chk32(32'(agg_request), 32'h0);
        chk32(32'(irq), 32'h0);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        stop_test();
    end
endmodule
